// File: msir_pkg.sv
// msir_pkg: offsets, field positions, reset values and carriers
// for the mac status and interrupt register block.
// assumes a 32-bit apb slave on pclk at 40 mhz.
package msir_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IRQ_W = 14;
  localparam int unsigned RXS_W = 3;

  // register byte offsets
  localparam logic [7:0] OFS_TXQ_PTR = 8'h1c;
  localparam logic [7:0] OFS_RX_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] OFS_IRQ_DISABLE = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

  // receive status field positions
  localparam int unsigned RXS_BUF_UNAVAIL = 0;
  localparam int unsigned RXS_FRAME_STORED = 1;
  localparam int unsigned RXS_STORE_FAIL = 2;

  // interrupt status field positions
  localparam int unsigned IRQ_MGMT_OP_DONE = 0;
  localparam int unsigned IRQ_RX_DONE = 1;
  localparam int unsigned IRQ_RX_USED_DESC = 2;
  localparam int unsigned IRQ_TX_USED_DESC = 3;
  localparam int unsigned IRQ_TX_UNDERRUN = 4;
  localparam int unsigned IRQ_RETRY_LIMIT = 5;
  localparam int unsigned IRQ_TX_BUF_EXH = 6;
  localparam int unsigned IRQ_TX_DONE = 7;
  localparam int unsigned IRQ_RX_OVERRUN = 10;
  localparam int unsigned IRQ_BUS_ERR = 11;
  localparam int unsigned IRQ_PAUSE_RX = 12;
  localparam int unsigned IRQ_PAUSE_EXP = 13;

  // defined event positions, and values after reset
  localparam logic [13:0] IRQ_DEFINED = 14'h3cff;
  localparam logic [13:0] IRQ_MASK_RST = 14'h3cff;
  localparam logic [13:0] IRQ_STATUS_RST = 14'h0000;
  localparam logic [2:0] RXS_RST = 3'h0;
  localparam logic [31:0] TXQ_BASE_RST = 32'h0000_0000;

  // descriptor stepping
  localparam logic [31:0] TXQ_DESC_BYTES = 32'h0000_0008;
  localparam int unsigned TXQ_IDX_W = 10;

  // event strobes from the mac engines, one cycle each
  typedef struct packed {
    logic mgmt_op_done;
    logic rx_done;
    logic rx_frame_start;
    logic rx_fetch_fail;
    logic rx_fetch_ok;
    logic rx_store_late;
    logic rx_bus_err;
    logic rx_used_desc_hit;
    logic tx_used_desc_hit;
    logic tx_fetch_late;
    logic tx_bus_err;
    logic tx_used_mid_frame;
    logic retry_limit_hit;
    logic tx_buffers_exhausted;
    logic tx_done;
    logic tx_frame_start;
    logic tx_buf_next;
    logic tx_buf_wrap;
    logic pause_frame_rx;
    logic pause_expired;
  } msir_evt_t;

  // requests back to the dma engines
  typedef struct packed {
    logic rx_desc_refetch;
    logic rx_buf_reclaim;
    logic tx_abort;
    logic txq_reloaded;
  } msir_dma_req_t;

endpackage

// File: msir_regs.sv
// msir_regs: status flags, interrupt status, enable/disable/mask
// and transmit queue pointer of the mac, behind an apb slave.
// assumes event strobes are single pclk cycles from mac engines.
//
// Function
// - rx status bits 0..2, write one clears
// - buffer unavailable set on every failed fetch
// - refetch descriptor each new frame until valid
// - frame stored flag after complete frame write
// - store failure sets flag, reclaims the buffer
// - queue pointer reads frame-first buffer, write loads unless transmitting
// - irq bit 0 management done; read clears bits read
// - irq bit 1 on frame stored
// - irq bits 2, 3 used descriptor read
// - irq bit 4 on underrun or on pointer write while not transmitting
// - irq bit 5 on retry limit exceeded
// - irq bit 6 buffers exhausted, transmit error
// - irq bit 7 on frame transmitted
// - irq bit 10 when store failure flag sets
// - irq bit 11 on dma bus error
// - irq bit 12 on valid pause frame
// - irq bit 13 when pause counter hits zero
// - enable register write-only, ones unmask
// - disable register write-only, ones mask
// - mask register reads one when masked
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
module msir_regs
  import msir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire msir_evt_t evt,
  input wire logic tx_active,
  output msir_dma_req_t dma_req,
  output logic [31:0] tx_desc_addr,
  output logic irq
);

  // apb phases
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_setup;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access = access_phase & pwrite;
  assign rd_setup = setup_phase & ~pwrite;

  // address decode
  logic hit_txq;
  logic hit_rxs;
  logic hit_ists;
  logic hit_ien;
  logic hit_idis;
  logic hit_imask;
  logic hit_any;

  // one register word per aligned offset
  function automatic logic msir_hit(input logic [7:0] a, input logic [7:0] ofs);
    msir_hit = (a == ofs);
  endfunction

  assign hit_txq = msir_hit(paddr, OFS_TXQ_PTR);
  assign hit_rxs = msir_hit(paddr, OFS_RX_STATUS);
  assign hit_ists = msir_hit(paddr, OFS_IRQ_STATUS);
  assign hit_ien = msir_hit(paddr, OFS_IRQ_ENABLE);
  assign hit_idis = msir_hit(paddr, OFS_IRQ_DISABLE);
  assign hit_imask = msir_hit(paddr, OFS_IRQ_MASK);
  assign hit_any = hit_txq | hit_rxs | hit_ists | hit_ien | hit_idis | hit_imask;

  // write strobes
  logic wr_txq_req;
  logic wr_txq;
  logic wr_rxs;
  logic wr_ien;
  logic wr_idis;

  assign wr_txq_req = wr_access & hit_txq;
  // pointer writes while transmitting are dropped
  assign wr_txq = wr_txq_req & ~tx_active;
  assign wr_rxs = wr_access & hit_rxs;
  assign wr_ien = wr_access & hit_ien;
  assign wr_idis = wr_access & hit_idis;

  // receive status flags
  logic [2:0] rx_flags;
  logic [2:0] rx_set;
  logic [2:0] rx_clr;
  logic rx_store_fail_evt;

  assign rx_store_fail_evt = evt.rx_store_late | evt.rx_bus_err;
  assign rx_set[RXS_BUF_UNAVAIL] = evt.rx_fetch_fail;
  assign rx_set[RXS_FRAME_STORED] = evt.rx_done;
  assign rx_set[RXS_STORE_FAIL] = rx_store_fail_evt;
  assign rx_clr = wr_rxs ? pwdata[2:0] : 3'h0;

  msir_rx_flags u_rx_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_strobe(rx_set),
    .clr_strobe(rx_clr),
    .flags(rx_flags)
  );

  // transmit queue pointer
  logic [31:0] txq_frame_addr;

  msir_txq u_txq (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_txq),
    .wr_data(pwdata),
    .buf_next(evt.tx_buf_next),
    .buf_wrap(evt.tx_buf_wrap),
    .frame_start(evt.tx_frame_start),
    .cur_addr(tx_desc_addr),
    .frame_addr(txq_frame_addr)
  );

  // receive descriptor refetch tracking
  logic refetch_pending;
  logic next_refetch_pending;

  // a failure in the same cycle as a success wins
  assign next_refetch_pending = evt.rx_fetch_fail
    | (refetch_pending & ~evt.rx_fetch_ok);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refetch_pending <= 1'b0;
    else
      refetch_pending <= next_refetch_pending;
  end

  // interrupt event vector
  logic [13:0] irq_set;
  logic tx_underrun_evt;
  logic bus_err_evt;

  assign tx_underrun_evt = evt.tx_fetch_late | evt.tx_bus_err | evt.tx_used_mid_frame;
  assign bus_err_evt = evt.tx_bus_err | evt.rx_bus_err;

  assign irq_set[IRQ_MGMT_OP_DONE] = evt.mgmt_op_done;
  assign irq_set[IRQ_RX_DONE] = evt.rx_done;
  assign irq_set[IRQ_RX_USED_DESC] = evt.rx_used_desc_hit;
  assign irq_set[IRQ_TX_USED_DESC] = evt.tx_used_desc_hit;
  assign irq_set[IRQ_TX_UNDERRUN] = tx_underrun_evt | wr_txq;
  assign irq_set[IRQ_RETRY_LIMIT] = evt.retry_limit_hit;
  assign irq_set[IRQ_TX_BUF_EXH] = evt.tx_buffers_exhausted;
  assign irq_set[IRQ_TX_DONE] = evt.tx_done;
  assign irq_set[9:8] = 2'h0;
  assign irq_set[IRQ_RX_OVERRUN] = rx_store_fail_evt;
  assign irq_set[IRQ_BUS_ERR] = bus_err_evt;
  assign irq_set[IRQ_PAUSE_RX] = evt.pause_frame_rx;
  assign irq_set[IRQ_PAUSE_EXP] = evt.pause_expired;

  // interrupt status, cleared on read
  logic [13:0] irq_status;
  logic [13:0] next_irq_status;
  logic [13:0] rd_clr_bits;
  logic [13:0] irq_clr;
  logic rd_ists_access;

  // only bits already latched into prdata are cleared
  assign rd_ists_access = access_phase & ~pwrite & hit_ists;
  assign irq_clr = rd_ists_access ? rd_clr_bits : 14'h0000;
  assign next_irq_status = ((irq_status & ~irq_clr) | irq_set) & IRQ_DEFINED;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= IRQ_STATUS_RST;
    else
      irq_status <= next_irq_status;
  end

  // interrupt mask
  logic [13:0] irq_mask;
  logic [13:0] next_irq_mask;
  logic [13:0] ien_bits;
  logic [13:0] idis_bits;

  assign ien_bits = wr_ien ? (pwdata[13:0] & IRQ_DEFINED) : 14'h0000;
  assign idis_bits = wr_idis ? (pwdata[13:0] & IRQ_DEFINED) : 14'h0000;
  // disable wins if both hit at once; zeros leave bits alone
  assign next_irq_mask = (irq_mask & ~ien_bits) | idis_bits;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= IRQ_MASK_RST;
    else
      irq_mask <= next_irq_mask;
  end

  // interrupt output
  logic next_irq;

  assign next_irq = |(next_irq_status & ~next_irq_mask);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

  // read data selection
  function automatic logic [31:0] msir_widen14(input logic [13:0] v);
    msir_widen14 = {18'h0, v};
  endfunction

  logic [31:0] rd_mux;
  logic [31:0] rdw_rxs;
  logic [31:0] rdw_ists;
  logic [31:0] rdw_imask;

  assign rdw_rxs = {29'h0, rx_flags};
  assign rdw_ists = msir_widen14(irq_status);
  assign rdw_imask = msir_widen14(irq_mask);
  assign rd_mux = hit_txq ? txq_frame_addr
    : hit_rxs ? rdw_rxs
    : hit_ists ? rdw_ists
    : hit_imask ? rdw_imask
    : 32'h0000_0000;

  // read data and error are captured in the setup cycle
  logic [31:0] next_prdata;
  logic [13:0] next_rd_clr_bits;
  logic next_pslverr;

  assign next_prdata = rd_setup ? rd_mux : prdata;
  assign next_rd_clr_bits = (rd_setup & hit_ists) ? irq_status : rd_clr_bits;
  assign next_pslverr = setup_phase ? ~hit_any : pslverr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= next_prdata;
  end

  // snapshot of the status word handed to software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_clr_bits <= 14'h0000;
    else
      rd_clr_bits <= next_rd_clr_bits;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= next_pslverr;
  end

  // zero wait state: answer in the first access cycle
  assign pready = 1'b1;

  // requests back to the dma engines
  msir_dma_req_t next_dma_req;

  assign next_dma_req.rx_desc_refetch = refetch_pending
    & evt.rx_frame_start;
  assign next_dma_req.rx_buf_reclaim = rx_store_fail_evt;
  assign next_dma_req.tx_abort = evt.tx_buffers_exhausted;
  assign next_dma_req.txq_reloaded = wr_txq;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dma_req <= '0;
    else
      dma_req <= next_dma_req;
  end

endmodule // msir_regs

// File: msir_regs_checker.sv
// msir_regs_checker: concurrent checks on the msir_regs ports.
// assumes it is bound to msir_regs and sees only its ports.
`timescale 1ns/10ps
module msir_regs_checker
  import msir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire msir_evt_t evt,
  input wire logic tx_active,
  input wire msir_dma_req_t dma_req,
  input wire logic [31:0] tx_desc_addr,
  input wire logic irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic pend;
  wire rd = psel && penable && !pwrite;
  wire txw = psel && penable && pwrite && paddr == OFS_TXQ_PTR;
  // refetch owed until a good descriptor fetch
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pend <= 1'b0;
    else if (evt.rx_fetch_fail || evt.rx_fetch_ok)
      pend <= evt.rx_fetch_fail;
  reclaim_a: assert property (
    evt.rx_store_late || evt.rx_bus_err |=> dma_req.rx_buf_reclaim)
    else $error("no reclaim after store failure");
  abort_a: assert property (
    evt.tx_buffers_exhausted |=> dma_req.tx_abort) else $error("no transmit abort");
  reload_a: assert property (
    txw && !tx_active |=> dma_req.txq_reloaded) else $error("no pointer reload pulse");
  locked_a: assert property (
    txw && tx_active |=> !dma_req.txq_reloaded) else $error("pointer reloaded while busy");
  ptr_load_a: assert property (
    txw && !tx_active && !evt.tx_buf_next && !evt.tx_buf_wrap
    |=> tx_desc_addr == $past(pwdata)) else $error("pointer not loaded");
  read_clear_a: assert property (
    rd && paddr == OFS_IRQ_STATUS && evt == '0 && $past(evt) == '0 |=> !irq)
    else $error("irq stays after status read");
  rx_high_a: assert property (
    rd && paddr == OFS_RX_STATUS |-> prdata[31:3] == 29'h0) else $error("rx status high bits");
  wo_zero_a: assert property (
    rd && (paddr == OFS_IRQ_ENABLE || paddr == OFS_IRQ_DISABLE) |-> prdata == 32'h0)
    else $error("write-only register reads nonzero");
  refetch_a: assert property (
    evt.rx_frame_start && pend && !evt.rx_fetch_ok |=> dma_req.rx_desc_refetch)
    else $error("no descriptor refetch");
  irq_c: cover property ($rose(irq));
  reload_c: cover property (dma_req.txq_reloaded);
  refetch_c: cover property (dma_req.rx_desc_refetch);
endmodule // msir_regs_checker

// File: msir_regs_tb_top.sv
// msir_regs_tb_top: apb master, event driver and reference model.
// assumes msir_pkg, msir_regs and msir_regs_checker compiled first.
`timescale 1ns/10ps
module msir_regs_tb_top
  import msir_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tx_active = 1'b0, pready, pslverr, irq, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, tx_desc_addr, rd, r, q;
  msir_evt_t evt = '0;
  msir_dma_req_t dma_req;
  logic [13:0] ist, msk;
  logic [2:0] rxs;
  int failures = 0;
  int tests_run = 0;
  always #12.5 pclk = ~pclk;
  msir_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .tx_active(tx_active), .dma_req(dma_req),
    .tx_desc_addr(tx_desc_addr), .irq(irq));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic msir_evt_t one(input int i);
    return msir_evt_t'(20'h1 << i);
  endfunction
  function automatic logic [13:0] ev_irq(input msir_evt_t e);
    return {e.pause_expired, e.pause_frame_rx,
      e.rx_bus_err | e.tx_bus_err, e.rx_store_late | e.rx_bus_err, 2'b00,
      e.tx_done, e.tx_buffers_exhausted, e.retry_limit_hit,
      e.tx_fetch_late | e.tx_bus_err | e.tx_used_mid_frame,
      e.tx_used_desc_hit, e.rx_used_desc_hit, e.rx_done, e.mgmt_op_done};
  endfunction
  task end_of_test(input int extra);
    failures += extra;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task rst;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ist = IRQ_STATUS_RST;
    msk = IRQ_MASK_RST;
    rxs = RXS_RST;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 40)
      end_of_test(1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == OFS_IRQ_ENABLE)
      msk = msk & ~(d[13:0] & IRQ_DEFINED);
    if (a == OFS_IRQ_DISABLE)
      msk = msk | (d[13:0] & IRQ_DEFINED);
    if (a == OFS_RX_STATUS)
      rxs = rxs & ~d[2:0];
    if (a == OFS_TXQ_PTR && !tx_active)
      ist[IRQ_TX_UNDERRUN] = 1'b1;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("offset %h", a), x, rd);
  endtask
  task rdis;
    rdc(OFS_IRQ_STATUS, {18'h0, ist});
    ist = '0;
  endtask
  task pulse(input msir_evt_t e);
    @(posedge pclk);
    evt <= e;
    @(posedge pclk);
    evt <= '0;
    ist = ist | ev_irq(e);
    rxs = rxs | {e.rx_store_late | e.rx_bus_err, e.rx_done, e.rx_fetch_fail};
    #1;
    chk("irq", {31'h0, |(ist & ~msk)}, {31'h0, irq});
  endtask
  initial
  begin
    r = 32'hf8d93e06;
    rst;
    rdc(OFS_IRQ_MASK, {18'h0, IRQ_MASK_RST});
    rdc(OFS_IRQ_STATUS, 32'h0);
    rdc(OFS_RX_STATUS, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STATUS, 32'hffff_ffff);
    rdc(OFS_IRQ_MASK, {18'h0, msk});
    rdc(OFS_IRQ_ENABLE, 32'h0);
    rdc(OFS_IRQ_DISABLE, 32'h0);
    rdc(8'h40, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    $display("test reset done");
    wr(OFS_IRQ_ENABLE, 32'hffff_ffff);
    rdc(OFS_IRQ_MASK, 32'h0);
    for (int i = 0; i < 20; i++)
    begin
      pulse(one(i));
      rdis;
      rdis;
      rdc(OFS_RX_STATUS, {29'h0, rxs});
      wr(OFS_RX_STATUS, 32'h7);
    end
    $display("test event walk done");
    pulse(one(16));
    wr(OFS_RX_STATUS, 32'h1);
    pulse(one(16));
    rdc(OFS_RX_STATUS, {29'h0, rxs});
    pulse(one(17));
    chk("refetch", 32'h1, {31'h0, dma_req.rx_desc_refetch});
    pulse(one(15));
    pulse(one(17));
    chk("refetch", 32'h0, {31'h0, dma_req.rx_desc_refetch});
    pulse(one(14));
    chk("reclaim", 32'h1, {31'h0, dma_req.rx_buf_reclaim});
    pulse(one(6));
    chk("abort", 32'h1, {31'h0, dma_req.tx_abort});
    rdis;
    $display("test rx dma done");
    wr(OFS_TXQ_PTR, 32'h0000_1000);
    #1;
    chk("desc addr", 32'h0000_1000, tx_desc_addr);
    pulse(one(3));
    pulse(one(3));
    chk("desc addr", 32'h0000_1010, tx_desc_addr);
    pulse(one(4));
    pulse(one(2));
    chk("desc addr", 32'h0000_1000, tx_desc_addr);
    rdc(OFS_TXQ_PTR, 32'h0000_1010);
    tx_active <= 1'b1;
    wr(OFS_TXQ_PTR, 32'h0000_2000);
    rdc(OFS_TXQ_PTR, 32'h0000_1010);
    rdis;
    tx_active <= 1'b0;
    $display("test queue pointer done");
    for (int k = 0; k < 300; k++)
    begin
      r = nx(r);
      q = nx(r);
      q = q & nx(q);
      case (r[2:0])
        3'h0: wr(OFS_IRQ_ENABLE, q);
        3'h1: wr(OFS_IRQ_DISABLE, q);
        3'h2: rdis;
        3'h3: rdc(OFS_IRQ_MASK, {18'h0, msk});
        3'h4: wr(OFS_RX_STATUS, q);
        3'h5: rdc(OFS_RX_STATUS, {29'h0, rxs});
        default: pulse(msir_evt_t'(q[19:0]));
      endcase
    end
    $display("test random done");
    rst;
    rdc(OFS_IRQ_MASK, {18'h0, IRQ_MASK_RST});
    rdc(OFS_RX_STATUS, 32'h0);
    $display("test second reset done");
    end_of_test(0);
  end
endmodule // msir_regs_tb_top

bind msir_regs msir_regs_checker u_chk (.*);

// File: msir_rx_flags.sv
// msir_rx_flags: write-one-to-clear receive status flags.
// assumes set and clear strobes come from pclk logic.
`timescale 1ns/10ps
module msir_rx_flags
  import msir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] set_strobe,
  input wire logic [2:0] clr_strobe,
  output logic [2:0] flags
);

  logic [2:0] next_flags;

  // a set in the clear cycle survives; writes never set
  assign next_flags = (flags & ~clr_strobe) | set_strobe;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= RXS_RST;
    else
      flags <= next_flags;
  end

endmodule // msir_rx_flags

// File: msir_txq.sv
// msir_txq: transmit descriptor list pointer.
// assumes the tx dma strobes buffer steps and frame starts on pclk.
`timescale 1ns/10ps
module msir_txq
  import msir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic buf_next,
  input wire logic buf_wrap,
  input wire logic frame_start,
  output logic [31:0] cur_addr,
  output logic [31:0] frame_addr
);

  logic [31:0] base;
  logic [TXQ_IDX_W-1:0] idx;
  logic [31:0] step;

  // index wraps on its own after 1024 buffers
  assign step = {19'h0, idx, 3'h0};
  assign cur_addr = base + step;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base <= TXQ_BASE_RST;
      idx <= '0;
      frame_addr <= TXQ_BASE_RST;
    end
    else if (wr_en)
    begin
      base <= wr_data;
      idx <= '0;
      frame_addr <= wr_data;
    end
    else
    begin
      if (buf_wrap)
        idx <= '0;
      else if (buf_next)
        idx <= idx + 1'b1;
      if (frame_start)
        frame_addr <= cur_addr;
    end
  end

endmodule // msir_txq
